// ---- design/t16mc_map.svh ----
// Register indexes, field positions, reset values and counts of the timer mode block
`ifndef T16MC_MAP_SVH
`define T16MC_MAP_SVH

// Register indexes; byte address is four times the index
`define T16MC_IDX_W 10
`define T16MC_IDX_CTRL_A 10'h090
`define T16MC_IDX_CTRL_B 10'h091
`define T16MC_IDX_CTRL_C 10'h092
`define T16MC_IDX_COUNT 10'h094
`define T16MC_IDX_CAPTURE 10'h096
`define T16MC_IDX_CMP_A 10'h098
`define T16MC_IDX_CMP_B 10'h09a
`define T16MC_IDX_STATUS 10'h0a0
`define T16MC_IDX_MASK 10'h0a1

// Control register A fields
`define T16MC_A_COM_A_LSB 6
`define T16MC_A_COM_B_LSB 4
// Control register B fields
`define T16MC_B_FILT_BIT 7
`define T16MC_B_EDGE_BIT 6
`define T16MC_B_WAVE_LSB 3
`define T16MC_B_CS_LSB 0
// Control register C strobes
`define T16MC_C_FORCE_A_BIT 7
`define T16MC_C_FORCE_B_BIT 6

// Status and mask bit positions
`define T16MC_ST_OVF 0
`define T16MC_ST_CMP_A 1
`define T16MC_ST_CMP_B 2
`define T16MC_ST_CAP 3

// Fixed top values
`define T16MC_TOP_MAX 16'hffff
`define T16MC_TOP_8BIT 16'h00ff
`define T16MC_TOP_9BIT 16'h01ff
`define T16MC_TOP_10BIT 16'h03ff

// Reset values
`define T16MC_RST_CTRL 8'h00
`define T16MC_RST_WORD 16'h0000

// Counts
`define T16MC_FILT_SAMPLES 4
`define T16MC_PRESC_BITS 10

// Bus response codes
`define T16MC_RESP_OKAY 2'b00
`define T16MC_RESP_SLVERR 2'b10

`endif

// ---- design/t16mc_pkg.sv ----
// Types shared by the timer mode, clock source and capture filter modules
`include "t16mc_map.svh"
package t16mc_pkg;

	// Waveform mode encoding
	typedef enum logic [3:0] {
		T16MC_NORMAL = 4'b0000, T16MC_PC8 = 4'b0001, T16MC_PC9 = 4'b0010,
		T16MC_PC10 = 4'b0011, T16MC_CTC_CMP = 4'b0100, T16MC_FAST8 = 4'b0101,
		T16MC_FAST9 = 4'b0110, T16MC_FAST10 = 4'b0111, T16MC_PFC_CAP = 4'b1000,
		T16MC_PFC_CMP = 4'b1001, T16MC_PC_CAP = 4'b1010, T16MC_PC_CMP = 4'b1011,
		T16MC_CTC_CAP = 4'b1100, T16MC_RESV = 4'b1101, T16MC_FAST_CAP = 4'b1110,
		T16MC_FAST_CMP = 4'b1111
	} t16mc_wave_t;

	// Counting style and compare update point
	typedef enum logic [1:0] {T16MC_NONPWM = 2'b00, T16MC_FAST = 2'b01, T16MC_DUAL = 2'b10}
		t16mc_cls_t;
	typedef enum logic [1:0] {T16MC_UPD_IMM = 2'b00, T16MC_UPD_BOT = 2'b01, T16MC_UPD_TOP = 2'b10}
		t16mc_upd_t;

	// Capture filter state
	typedef struct packed {
		logic [`T16MC_FILT_SAMPLES-1:0] hist;
		logic out;
	} t16mc_filt_t;

	// Clock source state
	typedef struct packed {
		logic [`T16MC_PRESC_BITS-1:0] presc;
		logic ext_meta;
		logic ext_sync;
		logic ext_prev;
		logic tick;
	} t16mc_clk_t;

	// Timer block state
	typedef struct packed {
		logic aw_got;
		logic [`T16MC_IDX_W-1:0] aw_idx;
		logic w_got;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [15:0] rdata;
		logic [1:0][1:0] com;
		t16mc_wave_t wave;
		logic filt_en;
		logic edge_sel;
		logic [2:0] cs;
		logic [15:0] cnt;
		logic down;
		logic [15:0] icr;
		logic [1:0][15:0] cmp_buf;
		logic [1:0][15:0] cmp_act;
		logic [1:0] oc;
		logic cap_prev;
		logic [3:0] status;
		logic [3:0] mask;
	} t16mc_state_t;

endpackage

// ---- design/t16mc_clock_source.sv ----
// Count clock selection: shared prescaler, external pin synchroniser and tick mux
`timescale 1ns/1ps
`include "t16mc_map.svh"
module t16mc_clock_source (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Selection and pin
	input wire logic [2:0] cs_i,
	input wire logic ext_clk_pin_i,
	// Count enable
	output logic tick_o
);
	import t16mc_pkg::*;

	t16mc_clk_t s;
	t16mc_clk_t next_s;

	// Prescaler runs free; taps are one-cycle pulses at its roll points
	always_comb begin
		next_s = s;
		next_s.presc = s.presc + 1'b1;
		next_s.ext_meta = ext_clk_pin_i;
		next_s.ext_sync = s.ext_meta;
		next_s.ext_prev = s.ext_sync;
		case (cs_i)
			3'h0: next_s.tick = 1'b0;
			3'h1: next_s.tick = 1'b1;
			3'h2: next_s.tick = &s.presc[2:0];
			3'h3: next_s.tick = &s.presc[5:0];
			3'h4: next_s.tick = &s.presc[7:0];
			3'h5: next_s.tick = &s.presc[9:0];
			3'h6: next_s.tick = s.ext_prev & ~s.ext_sync;
			3'h7: next_s.tick = ~s.ext_prev & s.ext_sync;
			default: next_s.tick = 1'b0;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;
endmodule

// ---- design/t16mc_capture_filter.sv ----
// Capture pin noise filter: output follows only after a run of equal samples
`timescale 1ns/1ps
`include "t16mc_map.svh"
module t16mc_capture_filter (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Pin and enable
	input wire logic pin_i,
	input wire logic en_i,
	// Filtered level
	output logic level_o
);
	import t16mc_pkg::*;

	t16mc_filt_t s;
	t16mc_filt_t next_s;

	// Shift in a sample each cycle; change only on a full run
	always_comb begin
		next_s = s;
		next_s.hist = {s.hist[`T16MC_FILT_SAMPLES-2:0], pin_i};
		if (!en_i) begin
			next_s.out = pin_i;
		end else if (&next_s.hist) begin
			next_s.out = 1'b1;
		end else if (~|next_s.hist) begin
			next_s.out = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level_o = s.out;
endmodule

// ---- design/t16mc_timer.sv ----
// Timer mode, clock select and input capture control with AXI4-Lite registers
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "t16mc_map.svh"
module t16mc_timer #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// AXI4-Lite write address and data
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic [2:0] s_axi_awprot_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	// AXI4-Lite write response
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	// AXI4-Lite read
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic [2:0] s_axi_arprot_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	// Pins
	input wire logic capture_input_pin_i,
	input wire logic external_count_clock_pin_i,
	output logic [1:0] wave_out_o,
	output logic [1:0] wave_out_en_o,
	// Interrupt
	output logic irq_o
);
	import t16mc_pkg::*;

	t16mc_state_t s;
	t16mc_state_t next_s;
	logic tick;
	logic cap_level;
	logic [1:0] match;
	logic [15:0] top;
	t16mc_cls_t cls;
	t16mc_upd_t upd;
	logic cap_is_top;

	// Byte-lane merge for the 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] be);
		merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	// Count enable from the selected source
	t16mc_clock_source u_clk (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.cs_i(s.cs),
		.ext_clk_pin_i(external_count_clock_pin_i),
		.tick_o(tick)
	);

	// Capture pin conditioning
	t16mc_capture_filter u_filt (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pin_i(capture_input_pin_i),
		.en_i(s.filt_en),
		.level_o(cap_level)
	);

	// Mode decode: top source, counting style and update point
	always_comb begin
		top = `T16MC_TOP_MAX;
		cls = T16MC_NONPWM;
		upd = T16MC_UPD_IMM;
		cap_is_top = 1'b0;
		case (s.wave)
			T16MC_NORMAL: top = `T16MC_TOP_MAX;
			T16MC_PC8: begin
				top = `T16MC_TOP_8BIT;
				cls = T16MC_DUAL;
				upd = T16MC_UPD_TOP;
			end
			T16MC_PC9: begin
				top = `T16MC_TOP_9BIT;
				cls = T16MC_DUAL;
				upd = T16MC_UPD_TOP;
			end
			T16MC_PC10: begin
				top = `T16MC_TOP_10BIT;
				cls = T16MC_DUAL;
				upd = T16MC_UPD_TOP;
			end
			T16MC_CTC_CMP: top = s.cmp_act[0];
			T16MC_FAST8: begin
				top = `T16MC_TOP_8BIT;
				cls = T16MC_FAST;
				upd = T16MC_UPD_BOT;
			end
			T16MC_FAST9: begin
				top = `T16MC_TOP_9BIT;
				cls = T16MC_FAST;
				upd = T16MC_UPD_BOT;
			end
			T16MC_FAST10: begin
				top = `T16MC_TOP_10BIT;
				cls = T16MC_FAST;
				upd = T16MC_UPD_BOT;
			end
			T16MC_PFC_CAP: begin
				top = s.icr;
				cls = T16MC_DUAL;
				upd = T16MC_UPD_BOT;
				cap_is_top = 1'b1;
			end
			T16MC_PFC_CMP: begin
				top = s.cmp_act[0];
				cls = T16MC_DUAL;
				upd = T16MC_UPD_BOT;
			end
			T16MC_PC_CAP: begin
				top = s.icr;
				cls = T16MC_DUAL;
				upd = T16MC_UPD_TOP;
				cap_is_top = 1'b1;
			end
			T16MC_PC_CMP: begin
				top = s.cmp_act[0];
				cls = T16MC_DUAL;
				upd = T16MC_UPD_TOP;
			end
			T16MC_CTC_CAP: begin
				top = s.icr;
				cap_is_top = 1'b1;
			end
			T16MC_FAST_CAP: begin
				top = s.icr;
				cls = T16MC_FAST;
				upd = T16MC_UPD_BOT;
				cap_is_top = 1'b1;
			end
			T16MC_FAST_CMP: begin
				top = s.cmp_act[0];
				cls = T16MC_FAST;
				upd = T16MC_UPD_BOT;
			end
			// Reserved code runs as normal mode; software must avoid it
			default: top = `T16MC_TOP_MAX;
		endcase
	end

	// Compare match per channel on a counting edge
	for (genvar i = 0; i < 2; i++) begin : g_match
		assign match[i] = tick && (s.cnt == s.cmp_act[i]);
	end

	// Next state: counter, waveform, capture, flags and bus
	always_comb begin
		logic at_top;
		logic at_bot;
		logic wrap;
		logic upd_now;
		logic cap_edge;
		logic wr_cmd;
		logic [1:0] force_cmp;
		logic [3:0] st_set;
		logic [3:0] st_clr;
		next_s = s;
		at_top = (s.cnt == top);
		at_bot = (s.cnt == 16'h0000);
		wrap = 1'b0;
		upd_now = 1'b0;
		st_set = 4'h0;
		st_clr = 4'h0;
		wr_cmd = s.aw_got && s.w_got && !s.bvalid;
		force_cmp = 2'b00;
		cap_edge = s.edge_sel ? (cap_level & ~s.cap_prev) : (~cap_level & s.cap_prev);
		// Strobes only act in non-PWM modes and never touch the counter
		if (wr_cmd && s.aw_idx == `T16MC_IDX_CTRL_C && s.w_strb[0] && cls == T16MC_NONPWM) begin
			force_cmp[0] = s.w_data[`T16MC_C_FORCE_A_BIT];
			force_cmp[1] = s.w_data[`T16MC_C_FORCE_B_BIT];
		end

		// Counting sequence
		if (cls != T16MC_DUAL) begin
			next_s.down = 1'b0;
		end
		if (tick) begin
			if (cls == T16MC_DUAL) begin
				if (!s.down) begin
					next_s.cnt = at_top ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
					next_s.down = at_top;
					upd_now = at_top && (upd == T16MC_UPD_TOP);
				end else begin
					next_s.cnt = at_bot ? s.cnt + 16'h0001 : s.cnt - 16'h0001;
					next_s.down = !at_bot;
					upd_now = at_bot && (upd == T16MC_UPD_BOT);
					st_set[`T16MC_ST_OVF] = at_bot;
				end
			end else begin
				wrap = at_top;
				next_s.cnt = at_top ? 16'h0000 : s.cnt + 16'h0001;
				upd_now = at_top && (upd == T16MC_UPD_BOT);
				if (cls == T16MC_FAST) begin
					st_set[`T16MC_ST_OVF] = at_top;
				end else begin
					st_set[`T16MC_ST_OVF] = (s.cnt == `T16MC_TOP_MAX);
				end
			end
			// With capture as top, the capture flag marks reaching top
			st_set[`T16MC_ST_CAP] = cap_is_top && at_top && !s.down;
		end
		st_set[`T16MC_ST_CMP_A] = match[0];
		st_set[`T16MC_ST_CMP_B] = match[1];

		// Compare update point: immediate follows the buffer each cycle
		if (upd == T16MC_UPD_IMM || upd_now) begin
			next_s.cmp_act = s.cmp_buf;
		end

		// Waveform outputs per channel
		for (int i = 0; i < 2; i++) begin
			if (cls == T16MC_NONPWM) begin
				if (match[i] || force_cmp[i]) begin
					case (s.com[i])
						2'b01: next_s.oc[i] = ~s.oc[i];
						2'b10: next_s.oc[i] = 1'b0;
						2'b11: next_s.oc[i] = 1'b1;
						default: next_s.oc[i] = s.oc[i];
					endcase
				end
			end else if (s.com[i][1]) begin
				if (cls == T16MC_FAST && wrap) begin
					next_s.oc[i] = ~s.com[i][0];
				end else if (match[i]) begin
					next_s.oc[i] = s.down ? ~s.com[i][0] : s.com[i][0];
				end
			end else if (s.com[i][0] && i == 0 && match[i] && (s.wave == T16MC_FAST_CAP
				|| s.wave == T16MC_FAST_CMP || s.wave == T16MC_PFC_CMP
				|| s.wave == T16MC_PC_CMP)) begin
				next_s.oc[i] = ~s.oc[i];
			end
		end

		// Pin capture on the selected edge, off while capture is top
		next_s.cap_prev = cap_level;
		if (cap_edge && !cap_is_top) begin
			next_s.icr = s.cnt;
			st_set[`T16MC_ST_CAP] = 1'b1;
		end

		// Bus address and data acceptance, either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_s.aw_got = 1'b1;
			next_s.aw_idx = s_axi_awaddr_i[`T16MC_IDX_W+1:2];
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_s.w_got = 1'b1;
			next_s.w_data = s_axi_wdata_i[15:0];
			next_s.w_strb = s_axi_wstrb_i[1:0];
		end
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
		end

		// Register write; software writes override the counter this cycle
		if (wr_cmd) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = `T16MC_RESP_OKAY;
			case (s.aw_idx)
				`T16MC_IDX_CTRL_A: if (s.w_strb[0]) begin
					next_s.com[0] = s.w_data[`T16MC_A_COM_A_LSB +: 2];
					next_s.com[1] = s.w_data[`T16MC_A_COM_B_LSB +: 2];
					next_s.wave[1:0] = s.w_data[1:0];
				end
				`T16MC_IDX_CTRL_B: if (s.w_strb[0]) begin
					next_s.filt_en = s.w_data[`T16MC_B_FILT_BIT];
					next_s.edge_sel = s.w_data[`T16MC_B_EDGE_BIT];
					next_s.wave[3:2] = s.w_data[`T16MC_B_WAVE_LSB +: 2];
					next_s.cs = s.w_data[`T16MC_B_CS_LSB +: 3];
				end
				`T16MC_IDX_CTRL_C: next_s.bresp = `T16MC_RESP_OKAY;
				`T16MC_IDX_COUNT: next_s.cnt = merge16(s.cnt, s.w_data, s.w_strb);
				`T16MC_IDX_CAPTURE: next_s.icr = merge16(s.icr, s.w_data, s.w_strb);
				`T16MC_IDX_CMP_A: next_s.cmp_buf[0] = merge16(s.cmp_buf[0], s.w_data, s.w_strb);
				`T16MC_IDX_CMP_B: next_s.cmp_buf[1] = merge16(s.cmp_buf[1], s.w_data, s.w_strb);
				`T16MC_IDX_MASK: if (s.w_strb[0]) begin
					next_s.mask = s.w_data[3:0];
				end
				default: next_s.bresp = `T16MC_RESP_SLVERR;
			endcase
		end

		// Register read; answer one cycle after the address is taken
		if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = `T16MC_RESP_OKAY;
			case (s_axi_araddr_i[`T16MC_IDX_W+1:2])
				`T16MC_IDX_CTRL_A: next_s.rdata = {8'h00, s.com[0], s.com[1], 2'b00, s.wave[1:0]};
				`T16MC_IDX_CTRL_B: next_s.rdata = {8'h00, s.filt_en, s.edge_sel, 1'b0,
					s.wave[3:2], s.cs};
				`T16MC_IDX_CTRL_C: next_s.rdata = 16'h0000;
				`T16MC_IDX_COUNT: next_s.rdata = s.cnt;
				`T16MC_IDX_CAPTURE: next_s.rdata = s.icr;
				`T16MC_IDX_CMP_A: next_s.rdata = s.cmp_buf[0];
				`T16MC_IDX_CMP_B: next_s.rdata = s.cmp_buf[1];
				`T16MC_IDX_STATUS: begin
					next_s.rdata = {12'h000, s.status};
					st_clr = 4'hf;
				end
				`T16MC_IDX_MASK: next_s.rdata = {12'h000, s.mask};
				default: begin
					next_s.rdata = 16'h0000;
					next_s.rresp = `T16MC_RESP_SLVERR;
				end
			endcase
		end

		// Sticky flags: a new event wins over the read clear
		next_s.status = (s.status & ~st_clr) | st_set;
	end

	// State register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Ready while the holding slot is free; one write and one read at a time
	assign s_axi_awready_o = !s.aw_got && !s.bvalid;
	assign s_axi_wready_o = !s.w_got && !s.bvalid;
	assign s_axi_arready_o = !s.rvalid;
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_rvalid_o = s.rvalid;
	assign s_axi_rdata_o = {16'h0000, s.rdata};
	assign s_axi_rresp_o = s.rresp;

	// Pins and interrupt
	assign wave_out_o = s.oc;
	assign wave_out_en_o = {|s.com[1], |s.com[0]};
	assign irq_o = |(s.status & s.mask);
endmodule

// ---- testbench/t16mc_timer_chk.sv ----
// Checker of bus handshakes and read-back fields of the timer block
`timescale 1ns/1ps
`include "t16mc_map.svh"
module t16mc_timer_chk #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Bus handshakes
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	// Interrupt
	input wire logic irq_o
);
	logic [9:0] rd_idx;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Index of the read in flight, so field checks know the register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_idx <= 10'h000;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rd_idx <= s_axi_araddr_i[11:2];
		end
	end
	a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address taken while a read answer is pending");
	a_aw_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while a write response is pending");
	a_read_latency: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer not one cycle after the address");
	a_write_latency: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
	a_resp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
	a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
		&& $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o)) else $error("read answer dropped");
	a_read_one_shot: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read answer repeated");
	a_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_force_reads_zero: assert property (
		s_axi_rvalid_o && rd_idx == `T16MC_IDX_CTRL_C |-> s_axi_rdata_o == 32'h00000000)
		else $error("force strobes read back nonzero");
	a_ctrl_b_gap: assert property (
		s_axi_rvalid_o && rd_idx == `T16MC_IDX_CTRL_B |-> !s_axi_rdata_o[5])
		else $error("unused control bit reads one");
	// Main scenarios reached
	cover property (s_axi_bvalid_o && s_axi_bready_i);
	cover property (s_axi_rvalid_o && s_axi_rresp_o == `T16MC_RESP_SLVERR);
	cover property ($rose(irq_o));
endmodule

bind t16mc_timer t16mc_timer_chk #(.ADDR_W(ADDR_W)) t16mc_timer_chk_inst (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_araddr_i(s_axi_araddr_i),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .irq_o(irq_o));

// ---- testbench/t16mc_pin_model.sv ----
// Pin-side model: capture input and external count clock
`timescale 1ns/1ps
module t16mc_pin_model (
	// Clock
	input wire logic ref_clk_i,
	// Pins into the timer
	output logic cap_pin_o,
	output logic ext_clk_o
);
	// Both idle low; the count clock stands still until told to move
	initial begin
		cap_pin_o = 1'b0;
		ext_clk_o = 1'b0;
	end
	// New capture level, held long enough for filter and capture
	task automatic cap_set(input logic v);
		@(posedge ref_clk_i);
		cap_pin_o <= v;
		repeat (10) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	// High pulse shorter than a filter run
	task automatic cap_glitch(input int n);
		@(posedge ref_clk_i);
		cap_pin_o <= 1'b1;
		repeat (n) @(posedge ref_clk_i);
		cap_pin_o <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	// One count clock edge, held past the synchroniser delay
	task automatic ext_level(input logic v);
		@(posedge ref_clk_i);
		ext_clk_o <= v;
		repeat (8) @(posedge ref_clk_i);
	endtask
endmodule

// ---- testbench/tb_t16mc_timer.sv ----
// Self-checking bench of the timer mode, clock select and capture block
`timescale 1ns/1ps
`include "t16mc_map.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
	$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_t16mc_timer;
	localparam logic [9:0] CA = `T16MC_IDX_CTRL_A, CB = `T16MC_IDX_CTRL_B;
	localparam logic [9:0] CC = `T16MC_IDX_CTRL_C, CNT = `T16MC_IDX_COUNT;
	localparam logic [9:0] CAP = `T16MC_IDX_CAPTURE, ST = `T16MC_IDX_STATUS;
	logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata;
	logic awready, wready, bvalid, arready, rvalid, irq, cap_pin, ext_pin;
	logic [1:0] bresp, rresp, wout, wout_en;
	logic [31:0] rdata;
	logic [2:0] prot;
	logic [3:0] wstrb;
	int failures, check_count;
	t16mc_timer t16mc_timer_inst (.ref_clk_i(ref_clk), .rst_i(rst),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
		.s_axi_awprot_i(prot), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(prot),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .capture_input_pin_i(cap_pin),
		.external_count_clock_pin_i(ext_pin), .wave_out_o(wout), .wave_out_en_o(wout_en),
		.irq_o(irq));
	t16mc_pin_model t16mc_pin_model_inst (.ref_clk_i(ref_clk), .cap_pin_o(cap_pin),
		.ext_clk_o(ext_pin));
	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic give_verdict();
		$display("failures %0d, checks %0d", failures, check_count);
		if (failures == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Write with address and data offered together; ready sampled at the falling edge
	task automatic bus_wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
		logic ta, tw, tr;
		logic [1:0] resp;
		@(posedge ref_clk);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(negedge ref_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tr = bvalid && bready;
			resp = bresp;
			@(posedge ref_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tr) begin
				bready <= 1'b0;
				`CHK(resp, er)
				return;
			end
		end
		failures++;
		give_verdict();
	endtask
	task automatic bus_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge ref_clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(negedge ref_clk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (ta) arvalid <= 1'b0;
			if (tr) begin
				rready <= 1'b0;
				return;
			end
		end
		failures++;
		give_verdict();
	endtask
	// Mapped write, then half a cycle so registered outputs have settled
	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		bus_wr(idx, d, `T16MC_RESP_OKAY);
		@(negedge ref_clk);
	endtask
	task automatic rd16(input logic [9:0] idx, output logic [15:0] v);
		logic [31:0] d;
		logic [1:0] r;
		bus_rd(idx, d, r);
		`CHK(r, `T16MC_RESP_OKAY)
		v = d[15:0];
	endtask
	task automatic rd_chk(input logic [9:0] idx, input logic [15:0] e);
		logic [15:0] v;
		rd16(idx, v);
		`CHK(v, e)
	endtask
	// Reset values, then every mode code except reserved 13 split over two registers
	task automatic sc_modes();
		`CHK(irq, 1'b0)
		rd_chk(CB, 16'h0000);
		rd_chk(CC, 16'h0000);
		for (int m = 0; m < 16; m++) begin
			if (m == 13) continue;
			wr(CA, 16'(m & 3));
			wr(CB, 16'((m >> 2) << 3));
			rd_chk(CA, 16'(m & 3));
			rd_chk(CB, 16'((m >> 2) << 3));
		end
	endtask
	// Stopped, prescaled and external count clocks
	task automatic sc_clock();
		int dv [6] = '{1, 1, 8, 64, 256, 1024};
		logic [15:0] c;
		int w;
		wr(CA, 16'h0000);
		for (int cs = 0; cs < 8; cs++) begin
			w = 4 * dv[cs % 6];
			wr(CB, 16'h0000);
			wr(CNT, 16'h0000);
			wr(CB, 16'(cs));
			if (cs < 6) repeat (w) @(posedge ref_clk);
			else begin
				repeat (3) begin
					t16mc_pin_model_inst.ext_level(1'b1);
					t16mc_pin_model_inst.ext_level(1'b0);
				end
				t16mc_pin_model_inst.ext_level(1'b1);
			end
			wr(CB, 16'h0000);
			rd16(CNT, c);
			if (cs == 0) `CHK(c, 16'h0000)
			else if (cs < 6) `CHK(c >= 16'(w / dv[cs] - 1) && c <= 16'(w / dv[cs] + 6), 1'b1)
			else `CHK(c, (cs == 7) ? 16'h0004 : 16'h0003)
			if (cs > 5) t16mc_pin_model_inst.ext_level(1'b0);
		end
	endtask
	// Tops and overflow points across mode families
	task automatic sc_tops();
		int md [8] = '{0, 5, 7, 1, 4, 15, 9, 11};
		logic [15:0] st [8] = '{16'hfff0, 16'h00f0, 16'h03f0, 16'h00f0, 16'h0050, 16'h0050,
			16'h0050, 16'h0050};
		logic [15:0] lo [8] = '{0, 0, 0, 16'h0080, 0, 0, 16'h0020, 16'h0020};
		logic [15:0] hi [8] = '{16'h0040, 16'h0040, 16'h0040, 16'h00ff, 16'h0040, 16'h0040,
			16'h0060, 16'h0060};
		logic fl [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		logic [15:0] c;
		for (int i = 0; i < 8; i++) begin
			wr(CB, 16'h0000);
			wr(CA, 16'h0000);
			wr(`T16MC_IDX_CMP_A, 16'h0060);
			wr(CNT, st[i]);
			rd16(ST, c);
			wr(`T16MC_IDX_MASK, 16'h0001);
			wr(CA, 16'(md[i] & 3));
			wr(CB, 16'(((md[i] >> 2) << 3) | 1));
			repeat (40) @(posedge ref_clk);
			wr(CB, 16'((md[i] >> 2) << 3));
			`CHK(irq, fl[i])
			rd16(CNT, c);
			`CHK(c >= lo[i] && c <= hi[i], 1'b1)
			rd16(ST, c);
			`CHK(c[0], fl[i])
		end
	endtask
	// Edge select, filter, masking and capture-as-top disconnect
	task automatic sc_capture();
		logic [15:0] s;
		wr(CA, 16'h0000);
		wr(CB, 16'h0040);
		wr(`T16MC_IDX_MASK, 16'h0008);
		rd16(ST, s);
		wr(CNT, 16'h1234);
		t16mc_pin_model_inst.cap_set(1'b1);
		`CHK(irq, 1'b1)
		rd_chk(CAP, 16'h1234);
		rd_chk(ST, 16'h0008);
		`CHK(irq, 1'b0)
		wr(CNT, 16'h5555);
		t16mc_pin_model_inst.cap_set(1'b0);
		rd_chk(CAP, 16'h1234);
		wr(CB, 16'h0000);
		wr(`T16MC_IDX_MASK, 16'h0000);
		t16mc_pin_model_inst.cap_set(1'b1);
		t16mc_pin_model_inst.cap_set(1'b0);
		`CHK(irq, 1'b0)
		rd_chk(CAP, 16'h5555);
		wr(CB, 16'h00c0);
		wr(CNT, 16'h0abc);
		t16mc_pin_model_inst.cap_glitch(3);
		rd_chk(CAP, 16'h5555);
		t16mc_pin_model_inst.cap_set(1'b1);
		rd_chk(CAP, 16'h0abc);
		t16mc_pin_model_inst.cap_set(1'b0);
		wr(CB, 16'h0058);
		wr(CNT, 16'h0def);
		t16mc_pin_model_inst.cap_set(1'b1);
		rd_chk(CAP, 16'h0abc);
		t16mc_pin_model_inst.cap_set(1'b0);
	endtask
	// Force strobes: bit positions, actions, no side effects, none in PWM
	task automatic sc_force();
		logic [1:0] w0;
		logic [15:0] s;
		wr(CB, 16'h0000);
		wr(CA, 16'h0070);
		wr(CNT, 16'h0042);
		`CHK(wout_en, 2'b11)
		rd16(ST, s);
		w0 = wout;
		wr(CC, 16'h0080);
		`CHK(wout, {w0[1], ~w0[0]})
		wr(CC, 16'h0040);
		`CHK(wout, {1'b1, ~w0[0]})
		rd_chk(CC, 16'h0000);
		rd_chk(CNT, 16'h0042);
		rd_chk(ST, 16'h0000);
		wr(CA, 16'h0071);
		wr(CB, 16'h0008);
		w0 = wout;
		wr(CC, 16'h00c0);
		`CHK(wout, w0)
	endtask
	// Unmapped place answers with an error and zero data
	task automatic sc_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		bus_wr(10'h0ff, 16'h00ff, `T16MC_RESP_SLVERR);
		bus_rd(10'h0ff, d, r);
		`CHK(r, `T16MC_RESP_SLVERR)
		`CHK(d, 32'h00000000)
		// Lane 0 off: 8-bit write dropped, 16-bit takes high byte only
		@(posedge ref_clk);
		wstrb <= 4'he;
		prot <= 3'b010;
		wr(CB, 16'h00ff);
		wr(`T16MC_IDX_CMP_A, 16'hffff);
		@(posedge ref_clk);
		wstrb <= 4'hf;
		prot <= 3'b000;
		rd_chk(CB, 16'h0008);
		rd_chk(`T16MC_IDX_CMP_A, 16'hff60);
	endtask
	// Reset for 16 cycles, then the scenarios in turn
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h00000000;
		prot = 3'b000;
		wstrb = 4'hf;
		failures = 0;
		check_count = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		sc_modes();
		sc_clock();
		sc_tops();
		sc_capture();
		sc_force();
		sc_unmapped();
		give_verdict();
	end
endmodule
